/* counter_array_pkg.sv */
// constants, register map and mode bit positions of the counter array
// assumes one 200 MHz clock and a byte-wide register port
// Operation
// R1 - one shared 16-bit counter times five modules, module n owns pin n
// R2 - two select bits choose prescaled tick, timer 0 overflow or external input
// R3 - external input advances on falling edge, driven no faster than clock/4
// R4 - idle-halt bit stops the counter while the chip idles
// R5 - guard-mode bit turns the watchdog role of module 4 on or off
// R6 - module 4 match with guard on raises internal reset, not the reset pin
// R7 - counter advances only while run bit 6 is set
// R8 - overflow sets flag bit 7, interrupt if enabled, hardware never clears it
// R9 - module match or capture sets flag bits 0..4, software clears them
// R10 - mode bit 0 lets the module flag request an interrupt
// R11 - mode bit 1 selects pulse-width mode
// R12 - mode bit 2 inverts the module pin on 16-bit equality
// R13 - mode bit 3 sets the module flag on 16-bit equality
// R14 - mode bit 4 captures on falling, bit 5 on rising, both on either
// R15 - mode bit 6 enables the comparator
// R16 - enabled pin edge copies counter bytes into value registers
// R17 - comparator plus match enable gives a software timer flagging equality
// R18 - toggle, match and comparator together give the high-speed output
// R19 - pwm pin low while count low byte below value low, reload on wrap
// R20 - pins and external input are synchronised before edge detection
// R21 - overflow is an enabled increment wrapping all ones to zero

`default_nettype none

package counter_array_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	localparam int NUM_MOD = 5;
	localparam int GUARD_MOD = 4;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [5:0] OFF_CONFIG = 6'h00;
	localparam logic [5:0] OFF_FLAGS = 6'h01;
	localparam logic [5:0] OFF_COUNT_LO = 6'h02;
	localparam logic [5:0] OFF_COUNT_HI = 6'h03;
	localparam logic [5:0] OFF_MODE_BASE = 6'h08;
	localparam logic [5:0] OFF_VALUE_BASE = 6'h10;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CFG_OVF_IRQ = 0;
	localparam int CFG_SRC_LO = 1;
	localparam int CFG_SRC_HI = 2;
	localparam int CFG_DIV_LO = 4;
	localparam int CFG_DIV_HI = 5;
	localparam int CFG_GUARD = 6;
	localparam int CFG_IDLE = 7;
	localparam int FLG_RUN = 6;
	localparam int FLG_OVF = 7;
	localparam int MD_IRQ = 0;
	localparam int MD_DUTY = 1;
	localparam int MD_FLIP = 2;
	localparam int MD_EQUAL = 3;
	localparam int MD_FALL = 4;
	localparam int MD_RISE = 5;
	localparam int MD_COMP = 6;

	// ****************************************
	// reset values and write masks
	// ****************************************
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] VALUE_RST = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [7:0] MODE_MASK = 8'h7f;
	localparam logic [7:0] FLAGS_MASK = 8'hdf;

	// ****************************************
	// prescaler divisors in clock cycles
	// ****************************************
	localparam int DIV_W = 7;
	localparam logic [6:0] DIV_BY4 = 7'h04;
	localparam logic [6:0] DIV_BY16 = 7'h10;
	localparam logic [6:0] DIV_BY64 = 7'h40;
endpackage

`default_nettype wire

/* edge_sync.sv */
// two-flop synchroniser with edge pulses for one pin
// assumes the pin is asynchronous to clock
`timescale 1ns/1ps
`default_nettype none

module edge_sync
	import counter_array_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic pinRaw,
	output logic rise,
	output logic fall
);
	typedef struct packed {
		logic meta;
		logic stable;
		logic prev;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	// first flop feeds only the second one
	always_comb
	begin
		s_d = s_q;
		s_d.meta = pinRaw; // [R20]
		s_d.stable = s_q.meta;
		s_d.prev = s_q.stable;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign rise = s_q.stable && !s_q.prev;
	assign fall = !s_q.stable && s_q.prev;

	AST_ONE_EDGE: assert property (@(posedge clock) disable iff (!rst_n)
		(rise |=> !rise) and (fall |=> !fall)) // [R20]
		else $error("edge pulse lasted more than one cycle");
endmodule

`default_nettype wire

/* capture_module.sv */
// one capture/compare module with its value registers and pin driver
// assumes advance and countNext come from the shared counter
`timescale 1ns/1ps
`default_nettype none

module capture_module
	import counter_array_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] mode,
	input wire logic advance,
	input wire logic [15:0] countNow,
	input wire logic [15:0] countNext,
	input wire logic pinRise,
	input wire logic pinFall,
	input wire logic wrLow,
	input wire logic wrHigh,
	input wire logic [7:0] wrData,
	output logic [7:0] valueLow,
	output logic [7:0] valueHigh,
	output logic pinOut,
	output logic pinOe,
	output logic match,
	output logic eventPulse
);
	typedef struct packed {
		logic [7:0] valLo;
		logic [7:0] valHi;
		logic pinOut;
	} chan_state_t;

	chan_state_t s_q;
	chan_state_t s_d;
	logic capture;

	assign match = mode[MD_COMP] && advance &&
		(countNext == {s_q.valHi, s_q.valLo}); // [R15]
	assign capture = (pinRise && mode[MD_RISE]) ||
		(pinFall && mode[MD_FALL]); // [R14]
	assign eventPulse = capture ||
		(match && mode[MD_EQUAL] && !mode[MD_DUTY]); // [R13] [R17]

	always_comb
	begin
		s_d = s_q;
		if (wrLow)
			s_d.valLo = wrData;
		if (wrHigh)
			s_d.valHi = wrData;
		// a capture in the same cycle beats a software write
		if (capture)
			{s_d.valHi, s_d.valLo} = countNow; // [R16]
		if (mode[MD_DUTY])
		begin
			if (advance && countNext[7:0] == 8'h00)
				s_d.valLo = s_d.valHi; // [R19]
			s_d.pinOut = (countNext[7:0] >= s_d.valLo); // [R11] [R19]
		end
		else if (mode[MD_FLIP] && match)
			s_d.pinOut = !s_q.pinOut; // [R12] [R18]
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			s_q <= '{valLo: VALUE_RST, valHi: VALUE_RST, pinOut: 1'b0};
		else
			s_q <= s_d;
	end

	assign valueLow = s_q.valLo;
	assign valueHigh = s_q.valHi;
	assign pinOut = s_q.pinOut;
	assign pinOe = mode[MD_DUTY] || mode[MD_FLIP];

	AST_CAPTURE_LOADS: assert property (@(posedge clock) disable iff (!rst_n)
		capture |=> {valueHigh, valueLow} == $past(countNow)) // [R16]
		else $error("capture did not load the counter value");
	AST_FLIP_TOGGLES: assert property (@(posedge clock) disable iff (!rst_n)
		(match && mode[MD_FLIP] && !mode[MD_DUTY])
		|=> pinOut != $past(pinOut)) // [R12]
		else $error("pin did not invert on match");
	AST_DUTY_LEVEL: assert property (@(posedge clock) disable iff (!rst_n)
		$past(mode[MD_DUTY]) |-> pinOut == (countNow[7:0] >= valueLow)) // [R19]
		else $error("pwm level disagrees with low byte compare");
	AST_NO_MATCH_OFF: assert property (@(posedge clock) disable iff (!rst_n)
		!mode[MD_COMP] |-> !match) // [R15]
		else $error("match without comparator enabled");
	COV_CAPTURE: cover property (@(posedge clock) disable iff (!rst_n)
		capture);
endmodule

`default_nettype wire

/* counter_array.sv */
// top of the programmable counter array: shared counter, register port,
// five capture/compare modules and the module 4 guard reset
// assumes register strobes are one cycle long and synchronous to clock
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module counter_array
	import counter_array_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [5:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic chipIdle,
	input wire logic timer0Overflow,
	input wire logic extTickIn,
	input wire logic [4:0] modulePinIn,
	output logic [4:0] modulePinOut,
	output logic [4:0] modulePinOe,
	output logic irqReq,
	output logic guardReset
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] flags;
		logic [15:0] count;
		logic [NUM_MOD-1:0][7:0] mode;
		logic [6:0] divCount;
		logic [7:0] rdData;
		logic irq;
		logic guard;
	} array_state_t;

	array_state_t s_q;
	array_state_t s_d;

	logic [6:0] divisor;
	logic preTick;
	logic extFall;
	logic srcTick;
	logic advance;
	logic stepped;
	logic overflow;
	logic [15:0] countNext;
	logic [NUM_MOD-1:0] pinRise;
	logic [NUM_MOD-1:0] pinFall;
	logic [NUM_MOD-1:0] wrLow;
	logic [NUM_MOD-1:0] wrHigh;
	logic [NUM_MOD-1:0] match;
	logic [NUM_MOD-1:0] eventPulse;
	logic [NUM_MOD-1:0][7:0] valueLow;
	logic [NUM_MOD-1:0][7:0] valueHigh;
	logic wrCountLo;
	logic wrCountHi;
	logic wrFlags;

	// ****************************************
	// input synchronisers
	// ****************************************
	edge_sync u_ext_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pinRaw(extTickIn),
		.rise(),
		.fall(extFall)
	);

	// ****************************************
	// count source and prescaler
	// ****************************************
	always_comb
	begin
		if (s_q.cfg[CFG_DIV_HI:CFG_DIV_LO] == 2'b00)
			divisor = DIV_BY4;
		else if (s_q.cfg[CFG_DIV_HI:CFG_DIV_LO] == 2'b01)
			divisor = DIV_BY16;
		else
			divisor = DIV_BY64;
	end

	// >= keeps the divider sane when the divisor is lowered mid-count
	assign preTick = (s_q.divCount >= 7'(divisor - 7'h01));

	always_comb
	begin
		if (!s_q.cfg[CFG_SRC_HI])
			srcTick = preTick; // [R2]
		else if (!s_q.cfg[CFG_SRC_LO])
			srcTick = timer0Overflow; // [R2]
		else
			srcTick = extFall; // [R2] [R3]
	end

	assign advance = s_q.flags[FLG_RUN] && srcTick &&
		!(s_q.cfg[CFG_IDLE] && chipIdle); // [R4] [R7]

	// a software counter write drops the step, so no module matches on it
	assign stepped = advance && !wrCountLo && !wrCountHi;

	// ****************************************
	// register decode
	// ****************************************
	assign wrCountLo = regWr && (regAddr == OFF_COUNT_LO);
	assign wrCountHi = regWr && (regAddr == OFF_COUNT_HI);
	assign wrFlags = regWr && (regAddr == OFF_FLAGS);

	// ****************************************
	// shared counter
	// ****************************************
	always_comb
	begin
		countNext = s_q.count;
		overflow = 1'b0;
		if (wrCountLo || wrCountHi)
		begin
			if (wrCountLo)
				countNext[7:0] = regWrData;
			if (wrCountHi)
				countNext[15:8] = regWrData;
		end
		else if (advance)
		begin
			countNext = 16'(s_q.count + 16'h0001); // [R1]
			overflow = (s_q.count == 16'hffff); // [R21]
		end
	end

	// ****************************************
	// capture/compare modules
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < NUM_MOD; g++)
		begin : gen_mod
			assign wrLow[g] = regWr &&
				(regAddr == 6'(OFF_VALUE_BASE + 2 * g));
			assign wrHigh[g] = regWr &&
				(regAddr == 6'(OFF_VALUE_BASE + 2 * g + 1));

			edge_sync u_pin_sync (
				.clock(clock),
				.rst_n(rst_n),
				.pinRaw(modulePinIn[g]), // [R20]
				.rise(pinRise[g]),
				.fall(pinFall[g])
			);

			capture_module u_mod (
				.clock(clock),
				.rst_n(rst_n),
				.mode(s_q.mode[g]),
				.advance(stepped),
				.countNow(s_q.count),
				.countNext(countNext),
				.pinRise(pinRise[g]),
				.pinFall(pinFall[g]),
				.wrLow(wrLow[g]),
				.wrHigh(wrHigh[g]),
				.wrData(regWrData),
				.valueLow(valueLow[g]),
				.valueHigh(valueHigh[g]),
				.pinOut(modulePinOut[g]), // [R1]
				.pinOe(modulePinOe[g]),
				.match(match[g]),
				.eventPulse(eventPulse[g])
			);
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		s_d = s_q;
		s_d.count = countNext;
		s_d.divCount = preTick ? 7'h00 : 7'(s_q.divCount + 7'h01);
		if (regWr && regAddr == OFF_CONFIG)
			s_d.cfg = regWrData;
		for (int n = 0; n < NUM_MOD; n++)
		begin
			if (regWr && regAddr == 6'(OFF_MODE_BASE + n))
				s_d.mode[n] = regWrData & MODE_MASK;
		end
		if (wrFlags)
			s_d.flags = regWrData & FLAGS_MASK;
		// hardware set wins over a software clear in the same cycle
		if (overflow)
			s_d.flags[FLG_OVF] = 1'b1; // [R8]
		s_d.flags[NUM_MOD-1:0] = s_d.flags[NUM_MOD-1:0] | eventPulse; // [R9]

		s_d.irq = (s_d.flags[FLG_OVF] && s_d.cfg[CFG_OVF_IRQ]); // [R8]
		for (int n = 0; n < NUM_MOD; n++)
		begin
			if (s_d.flags[n] && s_d.mode[n][MD_IRQ])
				s_d.irq = 1'b1; // [R10]
		end

		// internal reset pulse only, the chip reset pin is not touched
		s_d.guard = s_q.cfg[CFG_GUARD] && match[GUARD_MOD]; // [R5] [R6]

		s_d.rdData = 8'h00;
		if (regRd)
		begin
			if (regAddr == OFF_CONFIG)
				s_d.rdData = s_q.cfg;
			else if (regAddr == OFF_FLAGS)
				s_d.rdData = s_q.flags;
			else if (regAddr == OFF_COUNT_LO)
				s_d.rdData = s_q.count[7:0];
			else if (regAddr == OFF_COUNT_HI)
				s_d.rdData = s_q.count[15:8];
			else
			begin
				for (int n = 0; n < NUM_MOD; n++)
				begin
					if (regAddr == 6'(OFF_MODE_BASE + n))
						s_d.rdData = s_q.mode[n];
					if (regAddr == 6'(OFF_VALUE_BASE + 2 * n))
						s_d.rdData = valueLow[n];
					if (regAddr == 6'(OFF_VALUE_BASE + 2 * n + 1))
						s_d.rdData = valueHigh[n];
				end
			end
		end
	end

	// ****************************************
	// state register
	// ****************************************
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s_q.cfg <= CONFIG_RST;
			s_q.flags <= FLAGS_RST;
			s_q.count <= COUNT_RST;
			s_q.mode <= {NUM_MOD{MODE_RST}};
			s_q.divCount <= 7'h00;
			s_q.rdData <= 8'h00;
			s_q.irq <= 1'b0;
			s_q.guard <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign regRdData = s_q.rdData;
	assign irqReq = s_q.irq;
	assign guardReset = s_q.guard;

	// ****************************************
	// assertions
	// ****************************************
	AST_RUN_GATES: assert property (@(posedge clock) disable iff (!rst_n)
		(!s_q.flags[FLG_RUN] && !wrCountLo && !wrCountHi)
		|=> s_q.count == $past(s_q.count)) // [R7]
		else $error("counter moved with run bit clear");

	AST_IDLE_HALT: assert property (@(posedge clock) disable iff (!rst_n)
		(s_q.cfg[CFG_IDLE] && chipIdle) |-> !advance) // [R4]
		else $error("counter advanced in idle with halt set");

	AST_OVF_SET: assert property (@(posedge clock) disable iff (!rst_n)
		(advance && s_q.count == 16'hffff && !wrCountLo && !wrCountHi)
		|=> s_q.count == 16'h0000 && s_q.flags[FLG_OVF]) // [R8] [R21]
		else $error("wrap did not set overflow flag");

	AST_OVF_STICKY: assert property (@(posedge clock) disable iff (!rst_n)
		(s_q.flags[FLG_OVF] && !wrFlags) |=> s_q.flags[FLG_OVF]) // [R8]
		else $error("overflow flag cleared by hardware");

	AST_EVENT_SET: assert property (@(posedge clock) disable iff (!rst_n)
		eventPulse[0] ##1 !wrFlags[*2] |-> s_q.flags[0]) // [R9]
		else $error("module event flag not held");

	AST_EXT_STEP: assert property (@(posedge clock) disable iff (!rst_n)
		(s_q.cfg[CFG_SRC_HI] && s_q.cfg[CFG_SRC_LO] &&
		s_q.flags[FLG_RUN] && !(s_q.cfg[CFG_IDLE] && chipIdle) &&
		extFall && !wrCountLo && !wrCountHi)
		|=> s_q.count == 16'($past(s_q.count) + 16'h0001)) // [R2] [R3]
		else $error("external falling edge did not step the counter");

	AST_PRESCALE_GAP: assert property (@(posedge clock) disable iff (!rst_n)
		preTick |=> !preTick[*3]) // [R2]
		else $error("prescaled tick faster than clock over four");

	AST_GUARD: assert property (@(posedge clock) disable iff (!rst_n)
		(s_q.cfg[CFG_GUARD] && match[GUARD_MOD]) |=> guardReset) // [R6]
		else $error("module 4 match did not raise internal reset");

	AST_GUARD_OFF: assert property (@(posedge clock) disable iff (!rst_n)
		!$past(s_q.cfg[CFG_GUARD]) |-> !guardReset) // [R5]
		else $error("internal reset with guard mode off");

	AST_IRQ: assert property (@(posedge clock) disable iff (!rst_n)
		irqReq |-> (s_q.flags[FLG_OVF] && s_q.cfg[CFG_OVF_IRQ]) ||
		|(s_q.flags[NUM_MOD-1:0] & {s_q.mode[4][MD_IRQ],
		s_q.mode[3][MD_IRQ], s_q.mode[2][MD_IRQ], s_q.mode[1][MD_IRQ],
		s_q.mode[0][MD_IRQ]})) // [R10]
		else $error("interrupt without enabled flag");

	AST_READ_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
		(regRd && regAddr == OFF_FLAGS) |=> regRdData == $past(s_q.flags))
		else $error("flags read data wrong");

	COV_OVERFLOW: cover property (@(posedge clock) disable iff (!rst_n)
		overflow);
	COV_GUARD: cover property (@(posedge clock) disable iff (!rst_n)
		guardReset);
	COV_EXT: cover property (@(posedge clock) disable iff (!rst_n)
		extFall && advance);
	COV_PWM: cover property (@(posedge clock) disable iff (!rst_n)
		s_q.mode[1][MD_DUTY] && $rose(modulePinOut[1]));
endmodule

`default_nettype wire

/* pin_partner.sv */
// behavioural far side of the counter array: count input and module pins
// assumes the bench calls its tasks; levels change just after rising edges
`timescale 1ns/1ps
`default_nettype none

module pin_partner
(
	input wire logic clock,
	output logic extTickIn,
	output logic [4:0] pinLevel
);
	initial
	begin
		extTickIn = 1'b1;
		pinLevel = 5'h00;
	end

	// ****************************************
	// count input: low held four clocks, high held five between falls
	// ****************************************
	task automatic fall_ticks(input int n);
		repeat (n)
		begin
			@(posedge clock);
			extTickIn <= 1'b0;
			repeat (4) @(posedge clock);
			extTickIn <= 1'b1;
			repeat (4) @(posedge clock);
		end
	endtask

	task automatic set_pin(input int i, input logic v);
		@(posedge clock);
		pinLevel[i] <= v;
	endtask
endmodule
`default_nettype wire

/* programmable_counter_array_tb.sv */
// self-checking bench for the counter array through its register port
// assumes pin_partner drives the count input and undriven module pins
`timescale 1ns/1ps
`default_nettype none

module programmable_counter_array_tb;
	import counter_array_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] regAddr = 6'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic chipIdle = 1'b0;
	logic timer0Overflow = 1'b0;
	wire logic extTickIn;
	wire logic [4:0] partnerPin;
	wire logic [4:0] modulePinIn;
	logic [4:0] modulePinOut;
	logic [4:0] modulePinOe;
	logic [7:0] regRdData;
	logic irqReq;
	logic guardReset;
	int error_cnt = 0;
	int checks = 0;
	int hits = 0;
	logic [7:0] rdv;
	logic [15:0] cnt;
	logic [7:0] capMode [6] = '{8'h20, 8'h20, 8'h10, 8'h10, 8'h30, 8'h30};
	logic capLvl [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [15:0] capExp [6] = '{16'h1000, 16'h1000, 16'h1000, 16'h1003,
		16'h1004, 16'h1005};
	logic [7:0] divCfg [3] = '{8'h00, 8'h10, 8'h20};
	int divN [3] = '{4, 16, 64};

	always #2.5 clock = ~clock;

	// a pin the module drives reads back its own level
	assign modulePinIn = (modulePinOe & modulePinOut) | (~modulePinOe & partnerPin);

	counter_array dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .chipIdle(chipIdle),
		.timer0Overflow(timer0Overflow), .extTickIn(extTickIn),
		.modulePinIn(modulePinIn), .modulePinOut(modulePinOut),
		.modulePinOe(modulePinOe), .irqReq(irqReq), .guardReset(guardReset));

	pin_partner partner (.clock(clock), .extTickIn(extTickIn),
		.pinLevel(partnerPin));

	// ****************************************
	// access and check tasks
	// ****************************************
	task automatic end_sim();
		if (error_cnt == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clock);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(posedge clock);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clock);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask

	task automatic wr16(input logic [5:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 6'h01, v[15:8]);
	endtask

	task automatic rd16(input logic [5:0] a, output logic [15:0] v);
		logic [7:0] lo;
		logic [7:0] hi;
		rd(a, lo);
		rd(a + 6'h01, hi);
		v = {hi, lo};
	endtask

	function automatic logic [5:0] valAddr(input int n);
		return OFF_VALUE_BASE + 6'(2 * n);
	endfunction

	// timer 0 overflow pulses; guard pulses are counted meanwhile
	task automatic pulse(input int n);
		repeat (n)
		begin
			@(posedge clock);
			timer0Overflow <= 1'b1;
			@(posedge clock);
			timer0Overflow <= 1'b0;
			#1 hits += int'(guardReset);
			@(posedge clock);
			#1 hits += int'(guardReset);
		end
	endtask

	initial
	begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		end_sim();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		rd(OFF_CONFIG, rdv);
		chk(rdv, CONFIG_RST);
		rd(OFF_FLAGS, rdv);
		chk(rdv, FLAGS_RST);
		rd(6'h3f, rdv);
		chk(rdv, 8'h00);
		wr(OFF_MODE_BASE, 8'hff);
		rd(OFF_MODE_BASE, rdv);
		chk(rdv, MODE_MASK);
		wr(OFF_MODE_BASE, 8'h00);
		// timer 0 source and run bit, then idle halt
		wr(OFF_CONFIG, 8'h04);
		wr(OFF_FLAGS, 8'h40);
		pulse(5);
		rd16(OFF_COUNT_LO, cnt);
		chk(cnt, 16'h0005);
		wr(OFF_CONFIG, 8'h84);
		chipIdle <= 1'b1;
		pulse(2);
		rd16(OFF_COUNT_LO, cnt);
		chk(cnt, 16'h0005);
		chipIdle <= 1'b0;
		pulse(1);
		rd16(OFF_COUNT_LO, cnt);
		chk(cnt, 16'h0006);
		wr(OFF_FLAGS, 8'h00);
		pulse(3);
		rd16(OFF_COUNT_LO, cnt);
		chk(cnt, 16'h0006);
		// external count input
		wr(OFF_CONFIG, 8'h06);
		wr(OFF_FLAGS, 8'h40);
		partner.fall_ticks(3);
		pulse(2);
		rd16(OFF_COUNT_LO, cnt);
		chk(cnt, 16'h0009);
		// prescaled tick, ten ticks per divisor
		for (int i = 0; i < 3; i++)
		begin
			wr(OFF_CONFIG, divCfg[i]);
			wr16(OFF_COUNT_LO, 16'h0000);
			repeat (divN[i] * 10) @(posedge clock);
			rd16(OFF_COUNT_LO, cnt);
			chk(16'(cnt >= 16'h0009 && cnt <= 16'h000b), 16'h0001);
		end
		// overflow
		wr(OFF_FLAGS, 8'h00);
		wr(OFF_CONFIG, 8'h05);
		wr16(OFF_COUNT_LO, 16'hffff);
		wr(OFF_FLAGS, 8'h40);
		pulse(1);
		rd16(OFF_COUNT_LO, cnt);
		chk(cnt, 16'h0000);
		rd(OFF_FLAGS, rdv);
		chk(rdv, 8'hc0);
		chk(16'(irqReq), 16'h0001);
		pulse(2);
		rd(OFF_FLAGS, rdv);
		chk(rdv, 8'hc0);
		wr(OFF_FLAGS, 8'h40);
		@(posedge clock);
		#1 chk(16'(irqReq), 16'h0000);
		// software timer on module 0
		wr(OFF_CONFIG, 8'h04);
		wr(OFF_MODE_BASE, 8'h49);
		wr16(valAddr(0), 16'h0003);
		wr16(OFF_COUNT_LO, 16'h0000);
		pulse(2);
		rd(OFF_FLAGS, rdv);
		chk(rdv, 8'h40);
		pulse(1);
		rd(OFF_FLAGS, rdv);
		chk(rdv, 8'h41);
		chk(16'(irqReq), 16'h0001);
		wr(OFF_MODE_BASE, 8'h48);
		@(posedge clock);
		#1 chk(16'(irqReq), 16'h0000);
		wr(OFF_MODE_BASE, 8'h00);
		// high-speed output on module 1
		wr(OFF_MODE_BASE + 6'h01, 8'h4c);
		wr16(valAddr(1), 16'h0002);
		wr16(OFF_COUNT_LO, 16'h0000);
		chk(16'(modulePinOe[1]), 16'h0001);
		chk(16'(modulePinOut[1]), 16'h0000);
		pulse(2);
		chk(16'(modulePinOut[1]), 16'h0001);
		rd(OFF_FLAGS, rdv);
		chk(rdv, 8'h43);
		wr16(OFF_COUNT_LO, 16'h0000);
		pulse(2);
		chk(16'(modulePinOut[1]), 16'h0000);
		wr(OFF_MODE_BASE + 6'h01, 8'h00);
		// capture edges on module 2, counter stopped
		wr(OFF_FLAGS, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			wr(OFF_MODE_BASE + 6'h02, capMode[i]);
			wr16(OFF_COUNT_LO, 16'h1000 + 16'(i));
			partner.set_pin(2, capLvl[i]);
			repeat (6) @(posedge clock);
			rd16(valAddr(2), cnt);
			chk(cnt, capExp[i]);
		end
		rd(OFF_FLAGS, rdv);
		chk(rdv, 8'h04);
		wr(OFF_MODE_BASE + 6'h02, 8'h00);
		// pwm on module 3
		wr(OFF_MODE_BASE + 6'h03, 8'h42);
		wr16(valAddr(3), 16'h1080);
		wr16(OFF_COUNT_LO, 16'h0040);
		repeat (2) @(posedge clock);
		chk(16'(modulePinOe[3]), 16'h0001);
		chk(16'(modulePinOut[3]), 16'h0000);
		wr16(OFF_COUNT_LO, 16'h0090);
		repeat (2) @(posedge clock);
		chk(16'(modulePinOut[3]), 16'h0001);
		wr16(OFF_COUNT_LO, 16'h00ff);
		wr(OFF_FLAGS, 8'h40);
		pulse(1);
		rd(valAddr(3), rdv);
		chk(rdv, 8'h10);
		chk(16'(modulePinOut[3]), 16'h0000);
		wr(OFF_MODE_BASE + 6'h03, 8'h00);
		// guard mode on module 4
		wr(OFF_MODE_BASE + 6'h04, 8'h48);
		wr16(valAddr(4), 16'h0005);
		wr(OFF_CONFIG, 8'h44);
		wr16(OFF_COUNT_LO, 16'h0004);
		hits = 0;
		pulse(1);
		chk(16'(hits), 16'h0001);
		wr(OFF_CONFIG, 8'h04);
		wr16(OFF_COUNT_LO, 16'h0004);
		pulse(1);
		chk(16'(hits), 16'h0001);
		end_sim();
	end
endmodule
`default_nettype wire
